/* File: rtl/icc_capture_config.sv */
`timescale 1ns/10ps
module icc_capture_config (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        timer_input_one,
  input  wire logic        timer_input_two,
  input  wire logic        internal_trigger_line,
  input  wire logic        trigger_is_internal,
  input  wire logic [15:0] counter_value,
  output logic             capture_input_one,
  output logic             capture_input_two,
  output logic             cap1_pulse,
  output logic             cap2_pulse
);
  typedef struct packed {
    logic                  aw_held;
    logic [3:0]            aw_addr;
    logic                  w_held;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic [15:0]           mode;
    logic [1:0]            ena;
    logic [15:0]           cap1;
    logic [15:0]           cap2;
    logic                  ic1;
    logic                  ic2;
    logic                  p1;
    logic                  p2;
  } icc_top_st_t;

  icc_top_st_t st_r;
  icc_top_st_t st_nxt;
  logic [1:0]  sel   [2];
  logic [1:0]  event_division_factor   [2];
  logic [3:0]  flt   [2];
  logic        raw   [2];
  logic        filt  [2];
  logic        evt   [2];
  logic [15:0] wmode;
  logic [15:0] cur;
  logic        do_wr;

  assign sel[0] = st_r.mode[icc_pkg::SEL1_LSB +: 2];
  assign event_division_factor[0] = st_r.mode[icc_pkg::PSC1_LSB +: 2];
  assign flt[0] = st_r.mode[icc_pkg::FLT1_LSB +: 4];
  assign sel[1] = st_r.mode[icc_pkg::SEL2_LSB +: 2];
  assign event_division_factor[1] = st_r.mode[icc_pkg::PSC2_LSB +: 2];
  assign flt[1] = st_r.mode[icc_pkg::FLT2_LSB +: 4];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      // channel 2 maps its "same" code to input one as well, per its own table
      always_comb begin
        case (sel[gi])
          icc_pkg::SEL_SAME: raw[gi] = timer_input_one;
          icc_pkg::SEL_CROS: raw[gi] = timer_input_two;
          icc_pkg::SEL_TRIG: raw[gi] = internal_trigger_line && trigger_is_internal;
          default:           raw[gi] = 1'b0;
        endcase
      end

      icc_filter u_flt (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .flt_code (flt[gi]),
        .din      (raw[gi]),
        .dout     (filt[gi])
      );

      icc_prescaler u_psc (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .active   (st_r.ena[gi] && sel[gi] != icc_pkg::SEL_OUT),
        .psc_code (event_division_factor[gi]),
        .lvl      (filt[gi]),
        .cap_evt  (evt[gi])
      );
    end
  endgenerate

  // a write lands once address and data are both held and the last answer is gone
  assign do_wr = st_r.aw_held && st_r.w_held && !st_r.bvalid;

  always_comb begin
    st_nxt = st_r;
    cur    = st_r.mode;
    wmode  = st_r.mode;
    if (s_axi_awvalid && !st_r.aw_held) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_held) begin
      st_nxt.w_held = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    if (do_wr) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = icc_pkg::RESP_OKAY;
      case (st_r.aw_addr)
        icc_pkg::MODE_ADDR: begin
          if (st_r.w_strb[0]) wmode[7:0] = st_r.w_data[7:0];
          if (st_r.w_strb[1]) wmode[15:8] = st_r.w_data[15:8];
          // select fields locked while their channel is enabled
          if (st_r.ena[0]) wmode[icc_pkg::SEL1_LSB +: 2] = cur[icc_pkg::SEL1_LSB +: 2];
          if (st_r.ena[1]) wmode[icc_pkg::SEL2_LSB +: 2] = cur[icc_pkg::SEL2_LSB +: 2];
          st_nxt.mode = wmode;
        end
        icc_pkg::ENA_ADDR: begin
          if (st_r.w_strb[0]) st_nxt.ena = st_r.w_data[1:0];
        end
        icc_pkg::STAT_ADDR, icc_pkg::CAP1_ADDR: st_nxt.bresp = icc_pkg::RESP_OKAY;
        default: st_nxt.bresp = icc_pkg::RESP_SLVERR;
      endcase
    end
    if (st_r.bvalid && s_axi_bready) st_nxt.bvalid = 1'b0;
    if (s_axi_arvalid && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = icc_pkg::RESP_OKAY;
      case (s_axi_araddr)
        icc_pkg::MODE_ADDR: st_nxt.rdata = {16'h0000, st_r.mode};
        icc_pkg::ENA_ADDR:  st_nxt.rdata = {30'h00000000, st_r.ena};
        // filtered levels low, channel two capture high: one read serves both
        icc_pkg::STAT_ADDR: st_nxt.rdata = {st_r.cap2, 14'h0000, filt[1], filt[0]};
        icc_pkg::CAP1_ADDR: st_nxt.rdata = {16'h0000, st_r.cap1};
        default: begin
          st_nxt.rdata = 32'h00000000;
          st_nxt.rresp = icc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    st_nxt.ic1 = filt[0];
    st_nxt.ic2 = filt[1];
    st_nxt.p1  = evt[0];
    st_nxt.p2  = evt[1];
    if (evt[0]) st_nxt.cap1 = counter_value;
    if (evt[1]) st_nxt.cap2 = counter_value;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r      <= '0;
      st_r.mode <= icc_pkg::MODE_RESET;
      st_r.ena  <= icc_pkg::ENA_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready     = !st_r.aw_held;
  assign s_axi_wready      = !st_r.w_held;
  assign s_axi_bvalid      = st_r.bvalid;
  assign s_axi_bresp       = st_r.bresp;
  assign s_axi_arready     = !st_r.rvalid;
  assign s_axi_rvalid      = st_r.rvalid;
  assign s_axi_rdata       = st_r.rdata;
  assign s_axi_rresp       = st_r.rresp;
  assign capture_input_one = st_r.ic1;
  assign capture_input_two = st_r.ic2;
  assign cap1_pulse        = st_r.p1;
  assign cap2_pulse        = st_r.p2;

  sequence s_mode_write;
    do_wr && st_r.aw_addr == icc_pkg::MODE_ADDR;
  endsequence

  sequence s_read_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_sel1_locked : assert property (@(posedge aclk) disable iff (!aresetn)
    (s_mode_write and st_r.ena[0]) |=> $stable(st_r.mode[1:0]))
    else $error("channel one select changed while enabled");

  a_sel1_open : assert property (@(posedge aclk) disable iff (!aresetn)
    (s_mode_write and (!st_r.ena[0] && st_r.w_strb[0]))
      |=> st_r.mode[1:0] == $past(st_r.w_data[1:0]))
    else $error("channel one select not written while disabled");

  a_sel2_locked : assert property (@(posedge aclk) disable iff (!aresetn)
    (s_mode_write and st_r.ena[1]) |=> $stable(st_r.mode[9:8]))
    else $error("channel two select changed while enabled");

  a_sel2_open : assert property (@(posedge aclk) disable iff (!aresetn)
    (s_mode_write and (!st_r.ena[1] && st_r.w_strb[1]))
      |=> st_r.mode[9:8] == $past(st_r.w_data[9:8]))
    else $error("channel two select not written while disabled");

  a_psc2_field : assert property (@(posedge aclk) disable iff (!aresetn)
    (s_mode_write and st_r.w_strb[1])
      |=> st_r.mode[11:10] == $past(st_r.w_data[11:10]))
    else $error("channel two prescaler field not written");

  a_flt2_field : assert property (@(posedge aclk) disable iff (!aresetn)
    (s_mode_write and st_r.w_strb[1])
      |=> st_r.mode[15:12] == $past(st_r.w_data[15:12]))
    else $error("channel two filter field not written");

  a_cap_copy : assert property (@(posedge aclk) disable iff (!aresetn)
    evt[0] |=> (st_r.cap1 == $past(counter_value) && cap1_pulse))
    else $error("capture one did not latch counter");

  a_cap2_copy : assert property (@(posedge aclk) disable iff (!aresetn)
    evt[1] |=> (st_r.cap2 == $past(counter_value) && cap2_pulse))
    else $error("capture two did not latch counter");

  a_cap1_hold : assert property (@(posedge aclk) disable iff (!aresetn)
    !evt[0] |=> $stable(st_r.cap1))
    else $error("capture one moved without an event");

  a_route_one : assert property (@(posedge aclk) disable iff (!aresetn)
    (sel[0] == icc_pkg::SEL_OUT) |-> !raw[0])
    else $error("output channel passed an input");

  a_route_in1 : assert property (@(posedge aclk) disable iff (!aresetn)
    (sel[0] == icc_pkg::SEL_SAME) |-> raw[0] == timer_input_one)
    else $error("channel one code 01 not on input one");

  a_route_x1 : assert property (@(posedge aclk) disable iff (!aresetn)
    (sel[0] == icc_pkg::SEL_CROS) |-> raw[0] == timer_input_two)
    else $error("channel one code 10 not on input two");

  a_route_in2 : assert property (@(posedge aclk) disable iff (!aresetn)
    (sel[1] == icc_pkg::SEL_SAME) |-> raw[1] == timer_input_one)
    else $error("channel two code 01 not on input one");

  a_route_x2 : assert property (@(posedge aclk) disable iff (!aresetn)
    (sel[1] == icc_pkg::SEL_CROS) |-> raw[1] == timer_input_two)
    else $error("channel two code 10 not on input two");

  a_route_out2 : assert property (@(posedge aclk) disable iff (!aresetn)
    (sel[1] == icc_pkg::SEL_OUT) |-> !raw[1])
    else $error("output channel two passed an input");

  a_route_trig : assert property (@(posedge aclk) disable iff (!aresetn)
    (sel[1] == icc_pkg::SEL_TRIG) |-> raw[1] == (internal_trigger_line && trigger_is_internal))
    else $error("channel two trigger routing wrong");

  // the trigger line is dead unless the trigger source is internal
  a_route_trig1 : assert property (@(posedge aclk) disable iff (!aresetn)
    (sel[0] == icc_pkg::SEL_TRIG && !trigger_is_internal) |-> !raw[0])
    else $error("trigger routed without internal trigger source");

  a_trig1_pass : assert property (@(posedge aclk) disable iff (!aresetn)
    (sel[0] == icc_pkg::SEL_TRIG && trigger_is_internal) |-> raw[0] == internal_trigger_line)
    else $error("channel one trigger routing wrong");

  // answers stand until the master takes them
  a_bvalid_hold : assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response dropped before taken");

  a_rvalid_hold : assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready)
      |=> (s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)))
    else $error("read answer dropped or changed before taken");

  a_read_answer : assert property (@(posedge aclk) disable iff (!aresetn)
    s_read_take |=> s_axi_rvalid)
    else $error("read taken without an answer");

  a_write_answer : assert property (@(posedge aclk) disable iff (!aresetn)
    do_wr |=> s_axi_bvalid)
    else $error("write landed without a response");

endmodule : icc_capture_config

/* File: common/icc_pkg.sv */
package icc_pkg;

  // register map, byte addresses on the 32-bit bus
  localparam logic [3:0] MODE_ADDR = 4'h0;
  localparam logic [3:0] ENA_ADDR  = 4'h4;
  localparam logic [3:0] STAT_ADDR = 4'h8;
  localparam logic [3:0] CAP1_ADDR = 4'hC;

  // mode register field positions
  localparam int SEL1_LSB  = 0;
  localparam int PSC1_LSB  = 2;
  localparam int FLT1_LSB  = 4;
  localparam int SEL2_LSB  = 8;
  localparam int PSC2_LSB  = 10;
  localparam int FLT2_LSB  = 12;
  localparam int CH2_SHIFT = 8;

  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [1:0]  ENA_RESET  = 2'h0;

  // direction select codes
  localparam logic [1:0] SEL_OUT  = 2'h0;
  localparam logic [1:0] SEL_SAME = 2'h1;
  localparam logic [1:0] SEL_CROS = 2'h2;
  localparam logic [1:0] SEL_TRIG = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int CLK_MHZ = 100;

  typedef struct packed {
    logic [1:0] sel;
    logic [1:0] event_division_factor;
    logic [3:0] flt;
  } icc_chan_cfg_t;

  typedef struct packed {
    logic [15:0] cap_val;
    logic        cap_pulse;
  } icc_cap_t;

endpackage : icc_pkg

/* File: rtl/icc_filter.sv */
`timescale 1ns/10ps
module icc_filter (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [3:0] flt_code,
  input  wire logic       din,
  output logic            dout
);
  typedef struct packed {
    logic [4:0] div_cnt;
    logic [2:0] run;
    logic       lvl;
  } icc_flt_st_t;

  icc_flt_st_t st_r;
  icc_flt_st_t st_nxt;
  logic [4:0]  div_last;
  logic [2:0]  need_m1;
  logic        samp_en;

  // divider and count per code
  always_comb begin
    div_last = 5'h00;
    need_m1  = 3'h0;
    case (flt_code)
      4'h1: begin div_last = 5'h00; need_m1 = 3'h1; end
      4'h2: begin div_last = 5'h00; need_m1 = 3'h3; end
      4'h3: begin div_last = 5'h00; need_m1 = 3'h7; end
      4'h4: begin div_last = 5'h01; need_m1 = 3'h5; end
      4'h5: begin div_last = 5'h01; need_m1 = 3'h7; end
      4'h6: begin div_last = 5'h03; need_m1 = 3'h5; end
      4'h7: begin div_last = 5'h03; need_m1 = 3'h7; end
      4'h8: begin div_last = 5'h07; need_m1 = 3'h5; end
      4'h9: begin div_last = 5'h07; need_m1 = 3'h7; end
      4'hA: begin div_last = 5'h0F; need_m1 = 3'h4; end
      4'hB: begin div_last = 5'h0F; need_m1 = 3'h5; end
      4'hC: begin div_last = 5'h0F; need_m1 = 3'h7; end
      4'hD: begin div_last = 5'h1F; need_m1 = 3'h4; end
      4'hE: begin div_last = 5'h1F; need_m1 = 3'h5; end
      4'hF: begin div_last = 5'h1F; need_m1 = 3'h7; end
      default: begin div_last = 5'h00; need_m1 = 3'h0; end
    endcase
  end

  assign samp_en = (st_r.div_cnt >= div_last);

  always_comb begin
    st_nxt = st_r;
    st_nxt.div_cnt = samp_en ? 5'h00 : st_r.div_cnt + 5'h01;
    if (flt_code == 4'h0) begin
      st_nxt.lvl = din;
      st_nxt.run = 3'h0;
    end else if (samp_en) begin
      if (din == st_r.lvl) begin
        st_nxt.run = 3'h0;
      end else if (st_r.run >= need_m1) begin
        st_nxt.lvl = din;
        st_nxt.run = 3'h0;
      end else begin
        st_nxt.run = st_r.run + 3'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.lvl;

  a_bypass_follow : assert property (@(posedge aclk) disable iff (!aresetn)
    ($stable(flt_code) && flt_code == 4'h0) |=> dout == $past(din))
    else $error("bypassed filter did not follow input");

  a_no_early_flip : assert property (@(posedge aclk) disable iff (!aresetn)
    ($changed(dout) && $past(flt_code, 1) == 4'h2 && $past(flt_code, 2) == 4'h2
      && $past(flt_code, 3) == 4'h2 && $past(flt_code, 4) == 4'h2)
    |-> ($past(din, 1) == dout && $past(din, 2) == dout && $past(din, 3) == dout
      && $past(din, 4) == dout))
    else $error("filter changed level before four matching samples");

  a_need_two : assert property (@(posedge aclk) disable iff (!aresetn)
    (flt_code == 4'h1 && $changed(dout)) |-> $past(din) == dout)
    else $error("filter moved to level not seen on input");

endmodule : icc_filter

/* File: rtl/icc_prescaler.sv */
`timescale 1ns/10ps
module icc_prescaler (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       active,
  input  wire logic [1:0] psc_code,
  input  wire logic       lvl,
  output logic            cap_evt
);
  typedef struct packed {
    logic       prev;
    logic [2:0] cnt;
  } icc_psc_st_t;

  icc_psc_st_t st_r;
  icc_psc_st_t st_nxt;
  logic        edge_seen;
  logic [2:0]  last;

  // rising edge of the filtered input counts as one valid event
  assign edge_seen = lvl && !st_r.prev;
  assign last = 3'((4'h1 << psc_code) - 4'h1);

  always_comb begin
    st_nxt = st_r;
    st_nxt.prev = lvl;
    if (!active) begin
      st_nxt.cnt = 3'h0;
    end else if (edge_seen) begin
      st_nxt.cnt = (st_r.cnt >= last) ? 3'h0 : st_r.cnt + 3'h1;
    end
  end

  assign cap_evt = active && edge_seen && (st_r.cnt >= last);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  a_psc_one : assert property (@(posedge aclk) disable iff (!aresetn)
    (active && psc_code == 2'h0 && edge_seen) |-> cap_evt)
    else $error("divide-by-one missed an event");

  a_psc_gap : assert property (@(posedge aclk) disable iff (!aresetn)
    (cap_evt && psc_code == 2'h1 && $stable(psc_code)) |=> !cap_evt)
    else $error("divide-by-two captured twice in a row");

endmodule : icc_prescaler

/* File: test/icc_pin_model.sv */
`timescale 1ns/10ps
module icc_pin_model (
  input  wire logic aclk,
  output logic      timer_input_one,
  output logic      timer_input_two,
  output logic      internal_trigger_line,
  output logic      trigger_is_internal
);
  // trigger source starts internal so select code 11 is usable until the bench switches it with set_trig_src
  initial begin
    timer_input_one       = 1'h0;
    timer_input_two       = 1'h0;
    internal_trigger_line = 1'h0;
    trigger_is_internal   = 1'h1;
  end

  // lv is {trigger, input two, input one}; level lands after an edge, stands hold cycles
  task automatic drive(input logic [2:0] lv, input int hold);
    @(posedge aclk);
    {internal_trigger_line, timer_input_two, timer_input_one} <= lv;
    repeat (hold - 1) @(posedge aclk);
  endtask : drive

  // lets the bench take the trigger source away from the internal input
  task automatic set_trig_src(input logic v);
    @(posedge aclk);
    trigger_is_internal <= v;
  endtask : set_trig_src
endmodule : icc_pin_model

/* File: test/icc_capture_config_tb_top.sv */
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      $display("MISMATCH %s exp %0h got %0h", nm, exp, got); \
      error_cnt++; \
    end \
  end
module icc_capture_config_tb_top;
  localparam int DIVT[16] = '{1, 1, 1, 1, 2, 2, 4, 4, 8, 8, 16, 16, 16, 32, 32, 32};
  localparam int NT[16]   = '{1, 2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 5, 6, 8};
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp;
  logic        ti1, ti2, trg, trg_int, cin1, cin2, cp1, cp2;
  logic [15:0] cnt_val, r16, expm;
  logic [2:0]  lv;
  int          error_cnt, n_compared, ncap1, ncap2, hold;
  integer      seed;

  icc_capture_config u_icc_capture_config (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer_input_one(ti1), .timer_input_two(ti2), .internal_trigger_line(trg),
    .trigger_is_internal(trg_int), .counter_value(cnt_val),
    .capture_input_one(cin1), .capture_input_two(cin2), .cap1_pulse(cp1), .cap2_pulse(cp2)
  );
  icc_pin_model u_icc_pin_model (
    .aclk(aclk), .timer_input_one(ti1), .timer_input_two(ti2),
    .internal_trigger_line(trg), .trigger_is_internal(trg_int)
  );

  always #5 aclk = ~aclk;
  always @(negedge aclk) begin
    if (cp1 === 1'h1) ncap1++;
    if (cp2 === 1'h1) ncap2++;
  end

  // handshakes are judged at the negedge, where registered readies are settled
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_hit, w_hit, b_hit;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(negedge aclk);
      aw_hit = awvalid && (awready === 1'h1);
      w_hit  = wvalid && (wready === 1'h1);
      b_hit  = (bvalid === 1'h1);
      @(posedge aclk);
      if (aw_hit) awvalid <= 1'h0;
      if (w_hit) wvalid <= 1'h0;
    end while (!b_hit);
    bready <= 1'h0;
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    logic ar_hit, r_hit;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(negedge aclk);
      ar_hit = arvalid && (arready === 1'h1);
      r_hit  = (rvalid === 1'h1);
      d      = rdata;
      @(posedge aclk);
      if (ar_hit) arvalid <= 1'h0;
    end while (!r_hit);
    rready <= 1'h0;
  endtask : axi_rd

  function automatic logic route(input int s, input logic [2:0] l);
    return l[s - 1];
  endfunction : route

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  initial begin
    #300_000;
    error_cnt++;
    conclude();
  end

  initial begin
    seed = 32'h6245FE1B;
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {awaddr, araddr, wstrb, wdata, cnt_val} = 60'h0;
    error_cnt = 0;
    n_compared = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    axi_rd(icc_pkg::MODE_ADDR, rd);
    `CHK("mode_rst", icc_pkg::MODE_RESET, rd[15:0])
    axi_rd(icc_pkg::ENA_ADDR, rd);
    `CHK("ena_rst", icc_pkg::ENA_RESET, rd[1:0])
    repeat (6) begin
      r16 = 16'($random(seed));
      axi_wr(icc_pkg::MODE_ADDR, {16'h0, r16}, 4'h3);
      axi_wr(icc_pkg::MODE_ADDR, {16'h0, ~r16}, 4'h1);
      axi_rd(icc_pkg::MODE_ADDR, rd);
      `CHK("mode_rw", {r16[15:8], ~r16[7:0]}, rd[15:0])
    end
    for (int s = 1; s < 4; s++) begin
      axi_wr(icc_pkg::MODE_ADDR, {22'h0, s[1:0], 6'h0, s[1:0]}, 4'h3);
      repeat (6) begin
        lv = 3'($random(seed));
        u_icc_pin_model.drive(lv, 4);
        @(negedge aclk);
        `CHK("route1", route(s, lv), cin1)
        `CHK("route2", route(s, lv), cin2)
      end
    end
    u_icc_pin_model.set_trig_src(1'h0);
    u_icc_pin_model.drive(3'h7, 4);
    @(negedge aclk);
    `CHK("trig_ext1", 1'h0, cin1)
    `CHK("trig_ext2", 1'h0, cin2)
    u_icc_pin_model.set_trig_src(1'h1);
    u_icc_pin_model.drive(3'h0, 4);
    for (int k = 0; k < 4; k++) begin
      axi_wr(icc_pkg::ENA_ADDR, 32'h0, 4'hF);
      axi_wr(icc_pkg::MODE_ADDR, {20'h0, k[1:0], 2'h2, 4'h0, k[1:0], 2'h1}, 4'h3);
      axi_wr(icc_pkg::ENA_ADDR, 32'h3, 4'hF);
      ncap1 = 0;
      ncap2 = 0;
      // counter value is held across each event so the capture moment need not be exact
      repeat (16) begin
        cnt_val <= 16'($random(seed));
        u_icc_pin_model.drive(3'h3, 3);
        u_icc_pin_model.drive(3'h0, 3);
      end
      repeat (6) @(posedge aclk);
      `CHK("caps1", 16 >> k, ncap1)
      `CHK("caps2", 16 >> k, ncap2)
      axi_rd(icc_pkg::CAP1_ADDR, rd);
      `CHK("cap1", cnt_val, rd[15:0])
      axi_rd(icc_pkg::STAT_ADDR, rd);
      `CHK("cap2", cnt_val, rd[31:16])
      axi_wr(icc_pkg::MODE_ADDR, {20'h0, ~k[1:0], 2'h3, 4'h0, ~k[1:0], 2'h3}, 4'h3);
      axi_rd(icc_pkg::MODE_ADDR, rd);
      expm = {4'h0, ~k[1:0], 2'h2, 4'h0, ~k[1:0], 2'h1};
      `CHK("sel_lock", expm, rd[15:0])
    end
    axi_wr(icc_pkg::ENA_ADDR, 32'h0, 4'hF);
    for (int c = 1; c < 16; c++) begin
      axi_wr(icc_pkg::MODE_ADDR, {16'h0, c[3:0], 4'h1, c[3:0], 4'h1}, 4'h3);
      hold = (NT[c] - 1) * DIVT[c];
      u_icc_pin_model.drive(3'h1, hold);
      u_icc_pin_model.drive(3'h0, NT[c] * DIVT[c] + 8);
      @(negedge aclk);
      `CHK("glitch1", 1'h0, cin1)
      `CHK("glitch2", 1'h0, cin2)
      u_icc_pin_model.drive(3'h1, hold);
      @(negedge aclk);
      `CHK("early1", 1'h0, cin1)
      u_icc_pin_model.drive(3'h1, 2 * DIVT[c] + 8);
      @(negedge aclk);
      `CHK("late1", 1'h1, cin1)
      `CHK("late2", 1'h1, cin2)
      u_icc_pin_model.drive(3'h0, (NT[c] + 1) * DIVT[c] + 8);
    end
    conclude();
  end
endmodule : icc_capture_config_tb_top
